// ==== active_serial_config_loader.sv ====
// Active serial configuration loader: power-on delay, flash read, load, initialization.
// Assumes pins reach it unsynchronised, open-drain lines are resolved outside,
// and the configuration cells accept bytes with valid/ready on core_clk_in.
`include "ascl_params.svh"
`timescale 1ns/1ns
module active_serial_config_loader #(
	parameter int unsigned POR_FAST_CYC = `ASCL_POR_FAST_CYC,
	parameter int unsigned POR_STD_CYC  = `ASCL_POR_STD_CYC,
	parameter int unsigned RESTART_CYC  = `ASCL_RESTART_CYC,
	parameter int unsigned CFG_BYTES    = `ASCL_CFG_BYTES,
	parameter int          FIFO_DEPTH   = `ASCL_FIFO_DEPTH
) (
	input  wire logic             core_clk_in,
	input  wire logic             rst_in,
	input  wire logic [3:0]       scheme_select_in,
	input  wire logic             reload_request_low_in,
	input  wire logic             cfg_fault_low_in,
	output logic                  cfg_fault_low_out,
	output logic                  cfg_fault_low_oe_out,
	input  wire logic             load_complete_in,
	output logic                  load_complete_out,
	output logic                  load_complete_oe_out,
	input  wire logic             auto_restart_in,
	input  wire logic             compression_in,
	output logic                  flash_sclk_out,
	output logic                  flash_select_low_out,
	output logic                  cmd_addr_serial_out,
	output logic                  serial_pins_oe_out,
	input  wire logic             flash_data_in,
	output ascl_pkg::ascl_byte_t  cfg_byte_out,
	output logic                  cfg_byte_valid_out,
	input  wire logic             cfg_byte_ready_in,
	output logic                  user_io_enable_out,
	output logic                  cfg_error_out
);
	import ascl_pkg::*;

	logic [7:0]  sync1_r;
	logic [7:0]  sync2_r;
	logic [3:0]  scheme_s;
	logic        reload_line_s;
	logic        fault_line_s;
	logic        done_line_s;
	logic        data_s;
	ascl_state_t state_r;
	logic [31:0] tmr_r;
	logic [31:0] por_lim;
	logic        as_mode_r;
	logic        fast_r;
	logic        comp_r;
	logic [31:0] hdr_r;
	logic [5:0]  bit_cnt_r;
	logic [7:0]  rx_r;
	logic [2:0]  rx_bits_r;
	ascl_byte_t  raw_r;
	logic        raw_valid_r;
	logic        esc_r;
	logic [8:0]  rep_cnt_r;
	logic [23:0] out_cnt_r;
	logic        stream_end_r;
	logic        err_r;
	logic        sel_low_r;
	logic        fault_oe_r;
	logic        done_oe_r;
	logic        pins_oe_r;
	logic        user_r;
	ascl_byte_t  cfg_byte_r;
	logic        cfg_valid_r;
	logic        run;
	logic        rise_en;
	logic        fall_en;
	logic        in_data;
	logic        raw_is_lit;
	logic        raw_consume;
	logic        push;
	logic        pop;
	logic        flush;
	ascl_byte_t  emit_data;

	ascl_fifo_if #(.W(8)) fq ();

	// The scheme, reload, fault, done and data pins pass two flops; only the second stage is read
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
		end else begin
			sync1_r <= {scheme_select_in, reload_request_low_in, cfg_fault_low_in, load_complete_in, flash_data_in};
			sync2_r <= sync1_r;
		end
	end

	assign scheme_s      = sync2_r[7:4];
	assign reload_line_s = sync2_r[3];
	assign fault_line_s  = sync2_r[2];
	assign done_line_s   = sync2_r[1];
	assign data_s        = sync2_r[0];

	// Strap is caught once the synchroniser has settled after release
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			as_mode_r <= 1'b0;
			fast_r    <= 1'b0;
		end else if (state_r == ST_POR && tmr_r == `ASCL_STRAP_SETTLE) begin
			as_mode_r <= (scheme_s == `ASCL_SCHEME_AS_STD) || (scheme_s == `ASCL_SCHEME_AS_FAST);
			fast_r    <= (scheme_s == `ASCL_SCHEME_AS_FAST);
		end
	end

	assign por_lim = fast_r ? POR_FAST_CYC : POR_STD_CYC;

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r <= ST_POR;
			tmr_r   <= 32'h00000000;
		end else if (state_r != ST_POR && !reload_line_s) begin
			state_r <= ST_RESET;
			tmr_r   <= 32'h00000000;
		end else if ((state_r == ST_CMD || state_r == ST_DATA || state_r == ST_DRAIN || state_r == ST_WAIT_DONE
				|| state_r == ST_INIT) && !fault_line_s) begin
			state_r <= ST_RESET;
			tmr_r   <= 32'h00000000;
		end else begin
			case (state_r)
				ST_POR: begin
					tmr_r <= tmr_r + 32'h00000001;
					if (tmr_r > `ASCL_STRAP_SETTLE && tmr_r >= por_lim - 32'h00000001) begin
						state_r <= ST_RESET;
					end
				end
				ST_RESET: begin
					tmr_r <= 32'h00000000;
					if (as_mode_r && fault_line_s) begin
						state_r <= ST_CMD;
					end
				end
				ST_CMD: begin
					if (fall_en && bit_cnt_r == 6'(`ASCL_HDR_BITS - 1)) begin
						state_r <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (err_r) begin
						state_r <= ST_ERROR;
					end else if (stream_end_r) begin
						state_r <= ST_DRAIN;
					end
				end
				ST_DRAIN: begin
					if (!fq.rd_valid && !cfg_valid_r) begin
						state_r <= ST_WAIT_DONE;
					end
				end
				ST_WAIT_DONE: begin
					tmr_r <= 32'h00000000;
					if (done_line_s) begin
						state_r <= ST_INIT;
					end
				end
				ST_INIT: begin
					tmr_r <= tmr_r + 32'h00000001;
					if (tmr_r == `ASCL_INIT_CYC - 1) begin
						state_r <= ST_USER;
					end
				end
				ST_USER: begin
					tmr_r <= 32'h00000000;
				end
				ST_ERROR: begin
					tmr_r <= tmr_r + 32'h00000001;
					if (auto_restart_in && tmr_r >= RESTART_CYC - 1) begin
						state_r <= ST_RESET;
					end
				end
				default: begin
					state_r <= ST_POR;
					tmr_r   <= 32'h00000000;
				end
			endcase
		end
	end

	// Clock only runs while the link is busy; a held byte stalls it until the FIFO has room
	assign run     = (state_r == ST_CMD) || (state_r == ST_DATA && !raw_valid_r && !stream_end_r && !err_r);
	assign in_data = (state_r == ST_DATA) && !stream_end_r && !err_r;

	ascl_sclk_div #(.HALF(`ASCL_SCLK_HALF_CYC)) u_div (
		.clk_in   (core_clk_in),
		.rst_in   (rst_in),
		.run_in   (run),
		.sclk_out (flash_sclk_out),
		.rise_out (rise_en),
		.fall_out (fall_en)
	);

	// Header shifts on falling edges so the flash sees it stable at each rise
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hdr_r     <= {`ASCL_READ_CMD, `ASCL_START_ADDR};
			bit_cnt_r <= 6'h00;
		end else if (state_r != ST_CMD) begin
			hdr_r     <= {`ASCL_READ_CMD, `ASCL_START_ADDR};
			bit_cnt_r <= 6'h00;
		end else if (fall_en) begin
			hdr_r     <= {hdr_r[30:0], 1'b0};
			bit_cnt_r <= bit_cnt_r + 6'h01;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_r      <= 8'h00;
			rx_bits_r <= 3'h0;
		end else if (state_r != ST_DATA) begin
			rx_r      <= 8'h00;
			rx_bits_r <= 3'h0;
		end else if (fall_en && !raw_valid_r) begin
			rx_r      <= {rx_r[6:0], data_s};
			rx_bits_r <= rx_bits_r + 3'h1;
		end
	end

	// Compressed form: escape byte then N expands to N+1 zero bytes
	assign raw_is_lit  = raw_valid_r && rep_cnt_r == 9'h000 && !(comp_r && (esc_r || raw_r == `ASCL_RLE_ESC));
	assign emit_data   = (rep_cnt_r != 9'h000) ? 8'h00 : raw_r;
	assign fq.wr_valid = in_data && (rep_cnt_r != 9'h000 || raw_is_lit);
	assign fq.wr_data  = emit_data;
	assign push        = fq.wr_valid && fq.wr_ready;
	assign raw_consume = in_data && raw_valid_r && rep_cnt_r == 9'h000 && (!raw_is_lit || fq.wr_ready);
	assign flush       = (state_r == ST_RESET) || (state_r == ST_ERROR);

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			raw_r       <= 8'h00;
			raw_valid_r <= 1'b0;
			esc_r       <= 1'b0;
			rep_cnt_r   <= 9'h000;
			comp_r      <= 1'b0;
		end else if (state_r != ST_DATA) begin
			raw_valid_r <= 1'b0;
			esc_r       <= 1'b0;
			rep_cnt_r   <= 9'h000;
			comp_r      <= compression_in;
		end else begin
			if (fall_en && !raw_valid_r && rx_bits_r == 3'h7) begin
				raw_r       <= {rx_r[6:0], data_s};
				raw_valid_r <= 1'b1;
			end else if (raw_consume) begin
				raw_valid_r <= 1'b0;
			end
			if (raw_consume && comp_r && esc_r) begin
				esc_r     <= 1'b0;
				rep_cnt_r <= {1'b0, raw_r} + 9'h001;
			end else if (raw_consume && comp_r && raw_r == `ASCL_RLE_ESC) begin
				esc_r <= 1'b1;
			end else if (push && rep_cnt_r != 9'h000) begin
				rep_cnt_r <= rep_cnt_r - 9'h001;
			end
		end
	end

	// Stream ends on the byte count; a bad lead byte is a frame error
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			out_cnt_r    <= 24'h000000;
			stream_end_r <= 1'b0;
			err_r        <= 1'b0;
		end else if (state_r == ST_RESET) begin
			out_cnt_r    <= 24'h000000;
			stream_end_r <= 1'b0;
			err_r        <= 1'b0;
		end else if (push) begin
			out_cnt_r <= out_cnt_r + 24'h000001;
			if (out_cnt_r == 24'h000000 && emit_data != `ASCL_SYNC_BYTE) begin
				err_r <= 1'b1;
			end
			if (out_cnt_r == 24'(CFG_BYTES - 1)) begin
				stream_end_r <= 1'b1;
			end
		end
	end

	ascl_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in   (core_clk_in),
		.rst_in   (rst_in),
		.flush_in (flush),
		.q        (fq.fifo)
	);

	assign pop         = fq.rd_valid && (!cfg_valid_r || cfg_byte_ready_in);
	assign fq.rd_ready = pop;

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_byte_r  <= 8'h00;
			cfg_valid_r <= 1'b0;
		end else if (flush) begin
			cfg_valid_r <= 1'b0;
		end else if (pop) begin
			cfg_byte_r  <= fq.rd_data;
			cfg_valid_r <= 1'b1;
		end else if (cfg_byte_ready_in) begin
			cfg_valid_r <= 1'b0;
		end
	end

	// Pin drivers follow the state one cycle late, which keeps them glitch free
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sel_low_r  <= 1'b1;
			fault_oe_r <= 1'b1;
			done_oe_r  <= 1'b1;
			pins_oe_r  <= 1'b0;
			user_r     <= 1'b0;
		end else begin
			sel_low_r  <= !(state_r == ST_CMD || state_r == ST_DATA);
			fault_oe_r <= (state_r == ST_POR) || (state_r == ST_ERROR) || !reload_line_s;
			done_oe_r  <= !(state_r == ST_WAIT_DONE || state_r == ST_INIT || state_r == ST_USER);
			pins_oe_r  <= as_mode_r && state_r != ST_POR && state_r != ST_WAIT_DONE && state_r != ST_INIT
				&& state_r != ST_USER;
			user_r     <= (state_r == ST_USER);
		end
	end

	// Open-drain lines only ever pull low; the enable carries the level
	assign cfg_fault_low_out    = 1'b0;
	assign cfg_fault_low_oe_out = fault_oe_r;
	assign load_complete_out    = 1'b0;
	assign load_complete_oe_out = done_oe_r;
	assign flash_select_low_out = sel_low_r;
	assign cmd_addr_serial_out  = hdr_r[31];
	assign serial_pins_oe_out   = pins_oe_r;
	assign cfg_byte_out         = cfg_byte_r;
	assign cfg_byte_valid_out   = cfg_valid_r;
	assign user_io_enable_out   = user_r;
	assign cfg_error_out        = err_r;
endmodule

// ==== active_serial_config_loader_chk.sv ====
// Pin-level checks on the loader: power-on delay, link timing, completion and errors.
// Assumes pull-ups on the fault and load-complete lines and straps held through reset.
`timescale 1ns/1ns
module ascl_chk #(
	parameter int POR_FAST_CYC = 40,
	parameter int POR_STD_CYC  = 60,
	parameter int RESTART_CYC  = 20
) (
	input wire logic       core_clk_in,
	input wire logic       rst_in,
	input wire logic [3:0] scheme_select_in,
	input wire logic       reload_request_low_in,
	input wire logic       cfg_fault_low_oe_out,
	input wire logic       load_complete_in,
	input wire logic       load_complete_oe_out,
	input wire logic       auto_restart_in,
	input wire logic       flash_sclk_out,
	input wire logic       flash_select_low_out,
	input wire logic       cmd_addr_serial_out,
	input wire logic       serial_pins_oe_out,
	input wire logic       cfg_byte_valid_out,
	input wire logic       cfg_byte_ready_in,
	input wire logic       user_io_enable_out,
	input wire logic       cfg_error_out
);
	import ascl_pkg::*;
	localparam int RWIN = RESTART_CYC + 12;
	int   por_cnt;
	int   por_lim;
	int   hi_cnt;
	logic seen_r;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	assign por_lim = (scheme_select_in == 4'hD) ? POR_FAST_CYC : POR_STD_CYC;
	// Counts only up to the first release, so a reload does not skew it
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			por_cnt <= 0;
			seen_r <= 1'b0;
		end else begin
			por_cnt <= seen_r ? por_cnt : por_cnt + 1;
			seen_r <= seen_r | ~cfg_fault_low_oe_out;
		end
	end
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hi_cnt <= 0;
		end else begin
			hi_cnt <= load_complete_in ? hi_cnt + 1 : 0;
		end
	end
	chk_por_delay_len: assert property (
		!seen_r && !cfg_fault_low_oe_out && scheme_select_in inside {4'h2, 4'hD}
		|-> por_cnt >= por_lim && por_cnt <= por_lim + 4) else $error("power-on delay length off");
	chk_por_lines_low: assert property (
		!seen_r && cfg_fault_low_oe_out |-> load_complete_oe_out && flash_select_low_out && !user_io_enable_out)
		else $error("lines not held during power-on delay");
	chk_reload_resets: assert property (
		!reload_request_low_in |-> ##[1:5] (cfg_fault_low_oe_out && flash_select_low_out && !user_io_enable_out))
		else $error("reload low did not reset");
	chk_sclk_high_two: assert property (
		$rose(flash_sclk_out) |-> flash_sclk_out ##1 flash_sclk_out ##1 !flash_sclk_out)
		else $error("flash clock high phase wrong");
	chk_sclk_low_min: assert property ($fell(flash_sclk_out) |=> !flash_sclk_out)
		else $error("flash clock low phase too short");
	// Bit moves one core cycle after the clock falls, well before the next rise
	chk_cmd_on_fall: assert property (
		$changed(cmd_addr_serial_out) && !flash_select_low_out && !$past(flash_select_low_out)
		|-> $past(flash_sclk_out, 2) && !$past(flash_sclk_out)) else $error("command bit moved off the falling edge");
	chk_sclk_when_sel: assert property ($rose(flash_sclk_out) |-> !flash_select_low_out)
		else $error("flash clock without select");
	chk_pins_as_only: assert property (
		!flash_select_low_out |-> serial_pins_oe_out && scheme_select_in inside {4'h2, 4'hD})
		else $error("serial pins used outside active serial mode");
	chk_init_count: assert property (
		$rose(user_io_enable_out) |-> hi_cnt >= 3185 && hi_cnt <= 3195) else $error("init count wrong");
	// Pin drivers trail the error state by one cycle, so the check starts two cycles in
	chk_error_holds: assert property (
		cfg_error_out && $past(cfg_error_out, 2) |-> cfg_fault_low_oe_out && load_complete_oe_out)
		else $error("error did not hold fault and done low");
	chk_restart_bound: assert property (
		$rose(cfg_error_out) && auto_restart_in |-> ##[1:RWIN] !cfg_fault_low_oe_out)
		else $error("fault not released after restart time");
	cover property ($rose(user_io_enable_out));
	cover property ($rose(cfg_error_out));
	cover property (cfg_byte_valid_out && !cfg_byte_ready_in [*8]);
endmodule

bind active_serial_config_loader ascl_chk #(
	.POR_FAST_CYC(POR_FAST_CYC), .POR_STD_CYC(POR_STD_CYC), .RESTART_CYC(RESTART_CYC)
) u_chk (
	.core_clk_in(core_clk_in), .rst_in(rst_in), .scheme_select_in(scheme_select_in),
	.reload_request_low_in(reload_request_low_in), .cfg_fault_low_oe_out(cfg_fault_low_oe_out),
	.load_complete_in(load_complete_in), .load_complete_oe_out(load_complete_oe_out),
	.auto_restart_in(auto_restart_in), .flash_sclk_out(flash_sclk_out),
	.flash_select_low_out(flash_select_low_out), .cmd_addr_serial_out(cmd_addr_serial_out),
	.serial_pins_oe_out(serial_pins_oe_out), .cfg_byte_valid_out(cfg_byte_valid_out),
	.cfg_byte_ready_in(cfg_byte_ready_in), .user_io_enable_out(user_io_enable_out),
	.cfg_error_out(cfg_error_out)
);

// ==== active_serial_config_loader_tb.sv ====
// Bench: flash model on the link, byte scoreboard on the cell side.
// Assumes pull-ups on the fault and load-complete lines, resolved here from the enables.
`timescale 1ns/1ns
module active_serial_config_loader_tb;
	import ascl_pkg::*;
	localparam int NB = 16;
	logic            clk = 1'b0;
	logic            rst = 1'b1;
	logic [3:0]      strap = 4'h2;
	logic            reload_n = 1'b1;
	logic            auto_rs = 1'b0;
	logic            comp = 1'b0;
	logic            ready = 1'b0;
	logic            stall = 1'b0;
	logic            mon_on = 1'b0;
	logic [NB*8-1:0] image = '0;
	logic            fault_oe, done_oe, sclk, sel_n, cmd, pins_oe, fdata, bvalid, user_io, cerr;
	ascl_byte_t      cbyte;
	logic [31:0]     hdr;
	logic [7:0]      lf = 8'h50;
	logic [7:0]      rlf = 8'h50;
	ascl_byte_t      exp_q[$];
	int              error_cnt = 0;
	int              n_tests = 0;
	int              cyc = 0;

	always #4 clk = ~clk;

	active_serial_config_loader #(.POR_FAST_CYC(40), .POR_STD_CYC(60), .RESTART_CYC(20),
		.CFG_BYTES(NB), .FIFO_DEPTH(8)) uut (
		.core_clk_in(clk), .rst_in(rst), .scheme_select_in(strap), .reload_request_low_in(reload_n),
		.cfg_fault_low_in(!fault_oe), .cfg_fault_low_out(), .cfg_fault_low_oe_out(fault_oe),
		.load_complete_in(!done_oe), .load_complete_out(), .load_complete_oe_out(done_oe),
		.auto_restart_in(auto_rs), .compression_in(comp), .flash_sclk_out(sclk),
		.flash_select_low_out(sel_n), .cmd_addr_serial_out(cmd), .serial_pins_oe_out(pins_oe),
		.flash_data_in(fdata), .cfg_byte_out(cbyte), .cfg_byte_valid_out(bvalid),
		.cfg_byte_ready_in(ready), .user_io_enable_out(user_io), .cfg_error_out(cerr));

	ascl_flash_model #(.NB(NB)) flash (.sclk_in(sclk), .sel_low_in(sel_n), .cmd_in(cmd),
		.image_in(image), .data_out(fdata), .hdr_out(hdr));

	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	task automatic cmp_val(input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic cmp_byte(input ascl_byte_t e, input ascl_byte_t g);
		cmp_val({24'h000000, e}, {24'h000000, g});
	endtask

	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Builds the flash image and notes the bytes the cells should receive
	task automatic img(input logic c, input logic bad);
		ascl_byte_t b[NB];
		int i;
		int n;
		int k;
		b[0] = bad ? 8'h55 : 8'h6A;
		for (i = 1; i < NB; i++) begin
			lf = lfsr(lf);
			b[i] = lf;
		end
		if (c) begin
			b[3] = 8'h00;
			b[4] = 8'h03;
		end
		for (i = 0; i < NB; i++)
			image[NB*8-1-8*i -: 8] <= b[i];
		exp_q.delete();
		i = 0;
		n = 0;
		while (!bad && n < NB) begin
			if (c && b[i] == 8'h00) begin
				for (k = 0; k <= b[i+1]; k++)
					exp_q.push_back(8'h00);
				n += b[i+1] + 1;
				i += 2;
			end else begin
				exp_q.push_back(b[i]);
				n++;
				i++;
			end
		end
	endtask

	task automatic start_cfg(input logic [3:0] s, input logic c, input logic bad, input logic m);
		@(posedge clk);
		mon_on <= 1'b0;
		rst <= 1'b1;
		strap <= s;
		comp <= c;
		img(c, bad);
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		mon_on <= m;
	endtask

	task automatic wait_user();
		int n;
		n = 0;
		while (done_oe !== 1'b0 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		n = 0;
		while (user_io !== 1'b1 && n < 4000) begin
			@(negedge clk);
			n++;
		end
		cmp_val(32'h00000001, 32'(n >= 3185 && n <= 3196));
		cmp_val(32'h00000000, 32'(exp_q.size()));
		cmp_val({8'h03, 24'h000000}, hdr);
		cmp_val(32'h00000001, {31'h0, sel_n});
	endtask

	// Scoreboard side: each byte taken by the cells is matched to the oldest note
	always @(posedge clk) begin
		if (mon_on && bvalid === 1'b1 && ready) begin
			if (exp_q.size() == 0)
				cmp_val(32'h00000000, 32'h00000001);
			else
				cmp_byte(exp_q.pop_front(), cbyte);
		end
	end

	always @(posedge clk) begin
		rlf <= lfsr(rlf);
		ready <= !stall && (rlf[1:0] != 2'b00);
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	initial begin
		int k;
		int t;
		start_cfg(4'h2, 1'b0, 1'b0, 1'b1);
		wait_user();
		@(posedge clk);
		mon_on <= 1'b0;
		reload_n <= 1'b0;
		repeat (8) @(posedge clk);
		cmp_val(32'h00000006, {29'h0, fault_oe, sel_n, user_io});
		reload_n <= 1'b1;
		$display("test plain_std done");
		// Long stall fills the FIFO; the link clock must stop
		start_cfg(4'hD, 1'b1, 1'b0, 1'b1);
		for (k = 0; k < 2000 && bvalid !== 1'b1; k++)
			@(posedge clk);
		stall <= 1'b1;
		repeat (600) @(posedge clk);
		t = 0;
		for (k = 0; k < 100; k++) begin
			@(posedge clk);
			t += (sclk !== 1'b0);
		end
		cmp_val(32'h00000000, 32'(t));
		cmp_val(32'h00000001, {31'h0, bvalid});
		stall <= 1'b0;
		wait_user();
		$display("test comp_fast done");
		@(posedge clk);
		auto_rs <= 1'b1;
		start_cfg(4'h2, 1'b0, 1'b1, 1'b0);
		for (k = 0; k < 2000 && cerr !== 1'b1; k++)
			@(posedge clk);
		repeat (2) @(posedge clk);
		cmp_val(32'h0000000F, {28'h0, cerr, fault_oe, done_oe, sel_n});
		img(1'b0, 1'b0);
		mon_on <= 1'b1;
		wait_user();
		$display("test error_retry done");
		start_cfg(4'h0, 1'b0, 1'b0, 1'b0);
		repeat (200) @(posedge clk);
		cmp_val(32'h00000004, {29'h0, sel_n, pins_oe, fault_oe});
		$display("test non_as done");
		tally_and_finish();
	end
endmodule

// ==== ascl_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides and a synchronous flush.
// Assumes DEPTH is a power of two and one clock for both sides.
`timescale 1ns/1ns
module ascl_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic flush_in,
	ascl_fifo_if.fifo q
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_r [DEPTH];
	logic [AW:0]  wr_ptr_r;
	logic [AW:0]  rd_ptr_r;
	logic         full;
	logic         empty;
	logic         do_wr;
	logic         do_rd;

	// Extra pointer bit tells full from empty without a separate counter
	assign empty      = (wr_ptr_r == rd_ptr_r);
	assign full       = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);
	assign q.wr_ready = !full;
	assign q.rd_valid = !empty;
	assign q.rd_data  = mem_r[rd_ptr_r[AW-1:0]];
	assign do_wr      = q.wr_valid && !full;
	assign do_rd      = q.rd_ready && !empty;

	always_ff @(posedge clk_in) begin
		if (do_wr) begin
			mem_r[wr_ptr_r[AW-1:0]] <= q.wr_data;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else if (flush_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule

// ==== ascl_fifo_if.sv ====
// Valid/ready carrier between the loader core and its byte FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface ascl_fifo_if #(parameter int W = 8);
	logic [W-1:0] wr_data;
	logic         wr_valid;
	logic         wr_ready;
	logic [W-1:0] rd_data;
	logic         rd_valid;
	logic         rd_ready;

	modport fifo (input wr_data, input wr_valid, input rd_ready, output wr_ready, output rd_data, output rd_valid);
	modport prod (output wr_data, output wr_valid, output rd_ready, input wr_ready, input rd_data, input rd_valid);
endinterface

// ==== ascl_flash_model.sv ====
// Behavioural serial flash: shifts in the read header, then streams an image.
// Assumes the loader's clocking; data idles high by pull-up while deselected.
`timescale 1ns/1ns
module ascl_flash_model #(
	parameter int NB = 16
) (
	input  wire logic            sclk_in,
	input  wire logic            sel_low_in,
	input  wire logic            cmd_in,
	input  wire logic [NB*8-1:0] image_in,
	output logic                 data_out,
	output logic [31:0]          hdr_out
);
	int rises = 0;
	int bitp = 0;
	always @(posedge sclk_in or posedge sel_low_in) begin
		if (sel_low_in) begin
			rises <= 0;
		end else if (rises < 32) begin
			hdr_out <= {hdr_out[30:0], cmd_in};
			rises <= rises + 1;
		end
	end
	// Image repeats so a compressed stream never runs dry
	always @(negedge sclk_in or posedge sel_low_in) begin
		if (sel_low_in) begin
			bitp <= 0;
			data_out <= 1'b1;
		end else if (rises >= 32) begin
			data_out <= image_in[NB*8-1-bitp];
			bitp <= (bitp + 1) % (NB * 8);
		end
	end
endmodule

// ==== ascl_params.svh ====
// Constants for the active serial configuration loader: timing counts, codes, sizes.
// Assumes a single core clock of 125 MHz; the flash clock, power-on and restart counts are derived from it.
`ifndef ASCL_PARAMS_SVH
`define ASCL_PARAMS_SVH

`define ASCL_CLK_MHZ        125
`define ASCL_CLK_KHZ        125000
`define ASCL_SCLK_MAX_MHZ   40
`define ASCL_SCLK_HALF_CYC  ((`ASCL_CLK_MHZ + 2 * `ASCL_SCLK_MAX_MHZ - 1) / (2 * `ASCL_SCLK_MAX_MHZ))
`define ASCL_POR_FAST_MS    3
`define ASCL_POR_STD_MS     50
`define ASCL_POR_FAST_CYC   (`ASCL_POR_FAST_MS * `ASCL_CLK_KHZ + 1)
`define ASCL_POR_STD_CYC    (`ASCL_POR_STD_MS * `ASCL_CLK_KHZ + 1)
`define ASCL_RESTART_US     230
`define ASCL_RESTART_CYC    (`ASCL_RESTART_US * `ASCL_CLK_MHZ)
`define ASCL_INIT_CYC       3185
`define ASCL_STRAP_SETTLE   4
`define ASCL_SCHEME_AS_STD  4'h2
`define ASCL_SCHEME_AS_FAST 4'hD
`define ASCL_READ_CMD       8'h03
`define ASCL_START_ADDR     24'h000000
`define ASCL_HDR_BITS       32
`define ASCL_SYNC_BYTE      8'h6A
`define ASCL_RLE_ESC        8'h00
`define ASCL_FIFO_DEPTH     8
`define ASCL_CFG_BYTES      1024

`endif

// ==== ascl_pkg.sv ====
// Types shared by the active serial configuration loader modules.
// Assumes nothing of its surroundings.
package ascl_pkg;

	typedef logic [7:0] ascl_byte_t;

	typedef enum logic [3:0] {
		ST_POR       = 4'h0,
		ST_RESET     = 4'h1,
		ST_CMD       = 4'h2,
		ST_DATA      = 4'h3,
		ST_DRAIN     = 4'h4,
		ST_WAIT_DONE = 4'h5,
		ST_INIT      = 4'h6,
		ST_USER      = 4'h7,
		ST_ERROR     = 4'h8
	} ascl_state_t;

endpackage

// ==== ascl_sclk_div.sv ====
// Serial flash clock divider with one-cycle rise and fall enables.
// Assumes run_in from the same clock; the clock parks low whenever run_in is low.
`timescale 1ns/1ns
module ascl_sclk_div #(
	parameter int HALF = 2
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic run_in,
	output logic      sclk_out,
	output logic      rise_out,
	output logic      fall_out
);
	logic [7:0] cnt_r;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r    <= 8'h00;
			sclk_out <= 1'b0;
			rise_out <= 1'b0;
			fall_out <= 1'b0;
		end else if (!run_in) begin
			cnt_r    <= 8'h00;
			sclk_out <= 1'b0;
			rise_out <= 1'b0;
			fall_out <= 1'b0;
		end else if (cnt_r == 8'(HALF - 1)) begin
			// Pulses line up with the cycle in which the new level shows
			cnt_r    <= 8'h00;
			sclk_out <= !sclk_out;
			rise_out <= !sclk_out;
			fall_out <= sclk_out;
		end else begin
			cnt_r    <= cnt_r + 8'h01;
			rise_out <= 1'b0;
			fall_out <= 1'b0;
		end
	end
endmodule
